// ---- hdl/wrm_pkg.sv ----
// Constants, encodings and carriers for the watchdog recovery manager.
// Assumes one 25 MHz clock; times become cycles here.
package wrm_pkg;

    // Clock and time figures
    localparam longint unsigned CLK_HZ          = 25_000_000;
    localparam longint unsigned MS_PER_S        = 1000;
    localparam longint unsigned FPD_TIMEOUT_S   = 60;
    localparam longint unsigned LPD_TIMEOUT_S   = 60;
    localparam longint unsigned CWD_TIMEOUT_MS  = 90;
    localparam int unsigned     POLL_MS         = 100;
    localparam int unsigned     KICK_MS         = 50;

    // Derived cycle counts
    localparam longint unsigned MS_TICK_CYC     = CLK_HZ / MS_PER_S;
    localparam longint unsigned FPD_TIMEOUT_CYC = CLK_HZ * FPD_TIMEOUT_S;
    localparam longint unsigned LPD_TIMEOUT_CYC = CLK_HZ * LPD_TIMEOUT_S;
    localparam longint unsigned CWD_TIMEOUT_CYC = (CLK_HZ * CWD_TIMEOUT_MS) / MS_PER_S;

    // Scheduler sizing
    localparam int unsigned     SCHED_MAX_TASKS = 10;
    localparam logic [3:0]      TASK_POLL_ID    = 4'h0;
    localparam logic [3:0]      TASK_KICK_ID    = 4'h1;

    // Register byte offsets and reset values
    localparam logic [7:0]      REG_CTRL        = 8'h00;
    localparam logic [7:0]      REG_STATUS      = 8'h04;
    localparam logic [7:0]      REG_GEN_STORE5  = 8'h14;
    localparam logic [31:0]     CTRL_RESET      = 32'h0000_0000;
    localparam logic [31:0]     GS5_RESET       = 32'h0000_0000;

    // Control field positions and the general storage 5 done bit
    localparam int unsigned     CTRL_RECOVERY   = 0;
    localparam int unsigned     CTRL_ESCALATE   = 1;
    localparam int unsigned     CTRL_WDT_OPT    = 2;
    localparam int unsigned     CTRL_EM_OPT     = 3;
    localparam int unsigned     CTRL_SCHED_OPT  = 4;
    localparam int unsigned     CTRL_PL_CONFIG  = 5;
    localparam int unsigned     CTRL_SCOPE_LO   = 6;
    localparam int unsigned     GS5_DONE_BIT    = 0;

    // Status field positions
    localparam int unsigned     ST_FPD_BUSY     = 0;
    localparam int unsigned     ST_LPD_BUSY     = 1;
    localparam int unsigned     ST_CWD_POLL     = 2;
    localparam int unsigned     ST_CWD_ARMED    = 3;
    localparam int unsigned     ST_FPD_RUN      = 4;
    localparam int unsigned     ST_LPD_RUN      = 5;
    localparam int unsigned     ST_ISOLATE      = 6;
    localparam int unsigned     ST_INTERVAL     = 7;

    typedef enum logic [1:0] {WRM_MASTER_NONE, WRM_MASTER_APP, WRM_MASTER_RT, WRM_MASTER_PM} wrm_master_e;
    typedef enum logic [1:0] {WRM_SRC_FPD_WDT, WRM_SRC_LPD_WDT, WRM_SRC_CTL_WDT, WRM_SRC_OTHER} wrm_source_e;
    typedef enum logic [1:0] {WRM_SCOPE_SUBSYS, WRM_SCOPE_PS_ONLY, WRM_SCOPE_SYSTEM, WRM_SCOPE_SPARE} wrm_scope_e;
    typedef enum logic {WRM_ACT_SYS_RESET, WRM_ACT_INTERRUPT} wrm_action_e;

    typedef enum {WRM_FPD_IDLE, WRM_FPD_RESTART, WRM_FPD_IDLE_REQ, WRM_FPD_WAIT} wrm_fpd_state_e;
    typedef enum {WRM_LPD_IDLE, WRM_LPD_ISO_ON, WRM_LPD_ISO_OFF, WRM_LPD_ACT, WRM_LPD_WAIT} wrm_lpd_state_e;
    typedef enum {WRM_CWD_OFF, WRM_CWD_POLL, WRM_CWD_ARMED} wrm_cwd_state_e;

    // Error interrupt from the error manager
    typedef struct packed {
        logic        valid;
        wrm_master_e master;
        wrm_source_e source;
    } wrm_err_irq_s;

    // Reset and restart requests, one-cycle pulses
    typedef struct packed {
        logic sys_reset;
        logic ps_only_reset;
        logic app_restart;
        logic rt_restart;
    } wrm_reset_req_s;

    // Error actions handed to the error manager
    typedef struct packed {
        wrm_action_e full_power_domain;
        wrm_action_e low_power_domain;
        wrm_action_e ctl;
    } wrm_err_action_s;

endpackage : wrm_pkg

// ---- hdl/wrm_recovery_manager.sv ----
// Watchdog supervision and recovery sequencer with an APB register slave.
// Assumes error manager events arrive on err_irq and the
// boot loader sets its early-init flag in general storage 5.
//
// Function
// RULE1: Report each domain watchdog expiry to error manager
// RULE2: Recovery disabled unless recovery option set
// RULE3: No recovery: full-power action system reset
// RULE4: Recovery: interrupt action, manager starts watchdog
// RULE5: Recovery sets timer counter to interval mode
// RULE6: Full-power watchdog timeout is sixty seconds
// RULE7: Check application master and source, mark progress
// RULE8: Restart full-power watchdog after marking progress
// RULE9: Request application idle through timer channel
// RULE10: Failed attempt escalates by option and logic
// RULE11: No recovery: low-power action system reset
// RULE12: Low-power watchdog timeout is sixty seconds
// RULE13: Check realtime master and source, mark, restart
// RULE14: Apply then remove bus isolation on realtime
// RULE15: Act on scope: subsystem, system-only, whole system
// RULE16: Supervision needs watchdog, error, scheduler options
// RULE17: Poll early-init flag every 100 ms
// RULE18: On flag, arm controller watchdog at 90 ms
// RULE19: Kick controller watchdog every 50 ms
// RULE20: Controller watchdog expiry resets system in hardware
// RULE21: Boot loader writes early-init flag to storage
// RULE22: Restart state returns idle when restart completes
// RULE23: Scheduler holds up to ten millisecond tasks
//
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ps
module wrm_recovery_manager #(
    parameter longint unsigned MS_TICK     = wrm_pkg::MS_TICK_CYC,
    parameter longint unsigned FPD_TIMEOUT = wrm_pkg::FPD_TIMEOUT_CYC,
    parameter longint unsigned LPD_TIMEOUT = wrm_pkg::LPD_TIMEOUT_CYC,
    parameter longint unsigned CWD_TIMEOUT = wrm_pkg::CWD_TIMEOUT_CYC
) (
    input  wire logic                     ref_clk,          // Clock
    input  wire logic                     reset_n,          // Sync reset
    input  wire logic                     ce,               // Clock enable
    input  wire logic                     psel,             // APB select
    input  wire logic                     penable,          // APB enable
    input  wire logic                     pwrite,           // APB direction
    input  wire logic [31:0]              paddr,            // APB byte address
    input  wire logic [31:0]              pwdata,           // APB write data
    input  wire logic [3:0]               pstrb,            // APB byte strobes
    output logic      [31:0]              prdata,           // APB read data
    output logic                          pready,           // APB ready
    output logic                          pslverr,          // APB error
    input  wire logic                     app_kick,         // App heartbeat
    input  wire logic                     rt_kick,          // RT heartbeat
    input  wire wrm_pkg::wrm_err_irq_s    err_irq,          // Error event
    input  wire logic                     app_restart_done, // App restart over
    input  wire logic                     rt_restart_done,  // RT restart over
    output wrm_pkg::wrm_err_action_s      err_action,       // Error actions
    output logic                          fpd_report,       // Full-power expiry
    output logic                          lpd_report,       // Low-power expiry
    output wrm_pkg::wrm_reset_req_s       reset_req,        // Reset pulses
    output logic                          idle_request,     // Idle message
    output logic                          interval_mode,    // Interval mode
    output logic                          bus_isolation     // Isolation
);
    import wrm_pkg::*;

    localparam logic [31:0] MS_LOAD  = 32'(MS_TICK);
    localparam logic [31:0] FPD_LOAD = 32'(FPD_TIMEOUT);
    localparam logic [31:0] LPD_LOAD = 32'(LPD_TIMEOUT);
    localparam logic [31:0] CWD_LOAD = 32'(CWD_TIMEOUT);
    localparam logic [7:0]  POLL_LD  = 8'(POLL_MS);
    localparam logic [7:0]  KICK_LD  = 8'(KICK_MS);

    // Down-counter step shared by all three watchdogs
    function automatic logic [31:0] wd_step(input logic run, input logic reload,
                                            input logic [31:0] cnt, input logic [31:0] load);
        if (reload || (run && cnt <= 32'h0000_0001)) begin
            return load;
        end
        return run ? cnt - 32'h0000_0001 : cnt;
    endfunction : wd_step

    // Known register and aligned word
    function automatic logic addr_ok(input logic [31:0] a);
        return (a[31:8] == 24'h00_0000) &&
               (a[7:0] == REG_CTRL || a[7:0] == REG_STATUS || a[7:0] == REG_GEN_STORE5);
    endfunction : addr_ok

    // Byte-lane merge for writable registers
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    logic [31:0]    ctrl;
    logic [31:0]    gen_store5;
    logic [31:0]    status;
    logic [31:0]    fpd_cnt;
    logic [31:0]    lpd_cnt;
    logic [31:0]    cwd_cnt;
    logic [31:0]    ms_cnt;
    logic [7:0]     poll_cnt;
    logic [7:0]     kick_cnt;
    logic           fpd_run;
    logic           lpd_run;
    logic           ms_tick;
    wrm_fpd_state_e fpd_state;
    wrm_lpd_state_e lpd_state;
    wrm_cwd_state_e cwd_state;
    wrm_scope_e     scope;

    logic recovery;
    logic escalate;
    logic supervise;
    logic wr_commit;
    logic fpd_reload;
    logic lpd_reload;
    logic fpd_expire;
    logic lpd_expire;
    logic cwd_expire;
    logic fpd_hit;
    logic lpd_hit;
    logic fpd_fail;
    logic poll_due;
    logic kick_due;
    logic early_done;

    assign recovery   = ctrl[CTRL_RECOVERY]; // RULE2
    assign escalate   = ctrl[CTRL_ESCALATE];
    assign scope      = wrm_scope_e'(ctrl[CTRL_SCOPE_LO +: 2]);
    assign supervise  = ctrl[CTRL_WDT_OPT] & ctrl[CTRL_EM_OPT] & ctrl[CTRL_SCHED_OPT]; // RULE16
    assign early_done = gen_store5[GS5_DONE_BIT]; // RULE21
    assign wr_commit  = psel & penable & pready & pwrite & addr_ok(paddr);

    // Handler qualification: only the matching master and source count
    assign fpd_hit  = err_irq.valid & recovery & (err_irq.master == WRM_MASTER_APP)
                    & (err_irq.source == WRM_SRC_FPD_WDT); // RULE7
    assign lpd_hit  = err_irq.valid & recovery & (err_irq.master == WRM_MASTER_RT)
                    & (err_irq.source == WRM_SRC_LPD_WDT); // RULE13
    assign fpd_fail = fpd_hit & (fpd_state == WRM_FPD_WAIT); // RULE10

    // Watchdog reloads: heartbeat from the owner cluster or restart by the handler
    assign fpd_reload = app_kick | (fpd_state == WRM_FPD_RESTART); // RULE8
    assign lpd_reload = rt_kick | (lpd_hit && lpd_state == WRM_LPD_IDLE); // RULE13
    assign fpd_expire = fpd_run & ~fpd_reload & (fpd_cnt == 32'h0000_0001);
    assign lpd_expire = lpd_run & ~lpd_reload & (lpd_cnt == 32'h0000_0001);
    assign cwd_expire = (cwd_state == WRM_CWD_ARMED) & ~kick_due & (cwd_cnt == 32'h0000_0001);
    assign poll_due   = ms_tick & (poll_cnt == 8'h01);
    assign kick_due   = ms_tick & (kick_cnt == 8'h01);

    // APB slave: one wait state, then write commits and read data is presented
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (ce) begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~addr_ok(paddr);
            prdata  <= 32'h0000_0000;
            if (psel && penable && !pready && !pwrite && addr_ok(paddr)) begin
                case (paddr[7:0])
                    REG_CTRL:       prdata <= ctrl;
                    REG_STATUS:     prdata <= status;
                    REG_GEN_STORE5: prdata <= gen_store5;
                    default:        prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Software-owned registers; status is read only and ignores writes
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            ctrl       <= CTRL_RESET;
            gen_store5 <= GS5_RESET;
        end else if (ce && wr_commit) begin
            if (paddr[7:0] == REG_CTRL) begin
                ctrl <= merge(ctrl, pwdata, pstrb);
            end
            if (paddr[7:0] == REG_GEN_STORE5) begin
                gen_store5 <= merge(gen_store5, pwdata, pstrb); // RULE21
            end
        end
    end

    // Live state seen by software
    always_comb begin
        status               = 32'h0000_0000;
        status[ST_FPD_BUSY]  = (fpd_state != WRM_FPD_IDLE);
        status[ST_LPD_BUSY]  = (lpd_state != WRM_LPD_IDLE);
        status[ST_CWD_POLL]  = (cwd_state == WRM_CWD_POLL);
        status[ST_CWD_ARMED] = (cwd_state == WRM_CWD_ARMED);
        status[ST_FPD_RUN]   = fpd_run;
        status[ST_LPD_RUN]   = lpd_run;
        status[ST_ISOLATE]   = bus_isolation;
        status[ST_INTERVAL]  = interval_mode;
    end

    // Error actions follow the recovery option; controller watchdog always resets
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            err_action    <= '{full_power_domain: WRM_ACT_SYS_RESET, low_power_domain: WRM_ACT_SYS_RESET, ctl: WRM_ACT_SYS_RESET};
            interval_mode <= 1'b0;
        end else if (ce) begin
            err_action.full_power_domain <= recovery ? WRM_ACT_INTERRUPT : WRM_ACT_SYS_RESET;  // RULE3 RULE4
            err_action.low_power_domain <= recovery ? WRM_ACT_INTERRUPT : WRM_ACT_SYS_RESET;  // RULE11
            err_action.ctl <= WRM_ACT_SYS_RESET;                                  // RULE20
            interval_mode  <= recovery;                                           // RULE5
        end
    end

    // Full-power watchdog: manager starts it under recovery, else first heartbeat does
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            fpd_run <= 1'b0;
            fpd_cnt <= FPD_LOAD;
        end else if (ce) begin
            fpd_run <= fpd_run | recovery | app_kick; // RULE3 RULE4
            fpd_cnt <= wd_step(fpd_run, fpd_reload, fpd_cnt, FPD_LOAD); // RULE6
        end
    end

    // Low-power watchdog, same arrangement for the realtime cluster
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            lpd_run <= 1'b0;
            lpd_cnt <= LPD_LOAD;
        end else if (ce) begin
            lpd_run <= lpd_run | recovery | rt_kick; // RULE11
            lpd_cnt <= wd_step(lpd_run, lpd_reload, lpd_cnt, LPD_LOAD); // RULE12
        end
    end

    // Expiries go to the error manager, which applies the configured action
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            fpd_report <= 1'b0;
            lpd_report <= 1'b0;
        end else if (ce) begin
            fpd_report <= fpd_expire; // RULE1
            lpd_report <= lpd_expire; // RULE1
        end
    end

    // Full-power recovery: mark, restart watchdog, request idle, then wait
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            fpd_state <= WRM_FPD_IDLE;
        end else if (ce) begin
            case (fpd_state)
                WRM_FPD_IDLE: begin
                    if (fpd_hit) begin
                        fpd_state <= WRM_FPD_RESTART; // RULE7
                    end
                end
                WRM_FPD_RESTART:  fpd_state <= WRM_FPD_IDLE_REQ; // RULE8
                WRM_FPD_IDLE_REQ: fpd_state <= WRM_FPD_WAIT; // RULE9
                WRM_FPD_WAIT: begin
                    // A second expiry means the first attempt failed
                    if (fpd_fail || app_restart_done || !recovery) begin
                        fpd_state <= WRM_FPD_IDLE; // RULE22
                    end
                end
                default: fpd_state <= WRM_FPD_IDLE;
            endcase
        end
    end

    // Low-power recovery: mark and restart, isolate, release, act on scope
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            lpd_state <= WRM_LPD_IDLE;
        end else if (ce) begin
            case (lpd_state)
                WRM_LPD_IDLE: begin
                    if (lpd_hit) begin
                        lpd_state <= WRM_LPD_ISO_ON; // RULE13
                    end
                end
                WRM_LPD_ISO_ON:  lpd_state <= WRM_LPD_ISO_OFF; // RULE14
                WRM_LPD_ISO_OFF: lpd_state <= WRM_LPD_ACT; // RULE14
                WRM_LPD_ACT:     lpd_state <= WRM_LPD_WAIT; // RULE15
                WRM_LPD_WAIT: begin
                    if (rt_restart_done || !recovery) begin
                        lpd_state <= WRM_LPD_IDLE; // RULE22
                    end
                end
                default: lpd_state <= WRM_LPD_IDLE;
            endcase
        end
    end

    // Isolation stands for exactly one cycle before it is removed
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            bus_isolation <= 1'b0;
        end else if (ce) begin
            bus_isolation <= (lpd_state == WRM_LPD_ISO_ON); // RULE14
        end
    end

    // Idle message leaves on the dedicated timer channel
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            idle_request <= 1'b0;
        end else if (ce) begin
            idle_request <= (fpd_state == WRM_FPD_IDLE_REQ); // RULE9
        end
    end

    // Millisecond tick drives the scheduler tasks; two of the ten slots are used
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            ms_cnt  <= MS_LOAD;
            ms_tick <= 1'b0;
        end else if (ce) begin
            ms_cnt  <= wd_step(1'b1, 1'b0, ms_cnt, MS_LOAD); // RULE23
            ms_tick <= (ms_cnt == 32'h0000_0001);
        end
    end

    // Task intervals in milliseconds; poll task runs only while polling, kick task only while armed
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            poll_cnt <= POLL_LD;
            kick_cnt <= KICK_LD;
        end else if (ce) begin
            if (cwd_state != WRM_CWD_POLL) begin
                poll_cnt <= POLL_LD;
            end else if (ms_tick) begin
                poll_cnt <= (poll_cnt == 8'h01) ? POLL_LD : poll_cnt - 8'h01;     // RULE17
            end
            if (cwd_state != WRM_CWD_ARMED) begin
                kick_cnt <= KICK_LD;
            end else if (ms_tick) begin
                kick_cnt <= (kick_cnt == 8'h01) ? KICK_LD : kick_cnt - 8'h01;     // RULE19
            end
        end
    end

    // Controller watchdog: wait for early-init, arm, then keep kicking
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            cwd_state <= WRM_CWD_OFF;
        end else if (ce) begin
            case (cwd_state)
                WRM_CWD_OFF: begin
                    if (supervise) begin
                        cwd_state <= WRM_CWD_POLL; // RULE16
                    end
                end
                WRM_CWD_POLL: begin
                    if (!supervise) begin
                        cwd_state <= WRM_CWD_OFF;
                    end else if (poll_due && early_done) begin
                        cwd_state <= WRM_CWD_ARMED; // RULE17 RULE18
                    end
                end
                WRM_CWD_ARMED: begin
                    if (!supervise) begin
                        cwd_state <= WRM_CWD_OFF;
                    end
                end
                default: cwd_state <= WRM_CWD_OFF;
            endcase
        end
    end

    // Controller watchdog count; loaded on arming and on every kick
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            cwd_cnt <= CWD_LOAD;
        end else if (ce) begin
            cwd_cnt <= wd_step(cwd_state == WRM_CWD_ARMED,
                               cwd_state != WRM_CWD_ARMED || kick_due,
                               cwd_cnt, CWD_LOAD); // RULE18 RULE19
        end
    end

    // Restart and reset requests; escalation picks by option and logic state
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            reset_req <= '0;
        end else if (ce) begin
            reset_req.app_restart   <= fpd_fail & ~escalate;                      // RULE10
            reset_req.ps_only_reset <= (fpd_fail & escalate & ctrl[CTRL_PL_CONFIG])
                                     | (lpd_state == WRM_LPD_ACT && scope == WRM_SCOPE_PS_ONLY); // RULE10 RULE15
            reset_req.sys_reset     <= (fpd_fail & escalate & ~ctrl[CTRL_PL_CONFIG])
                                     | (lpd_state == WRM_LPD_ACT && scope >= WRM_SCOPE_SYSTEM)
                                     | cwd_expire;                                // RULE10 RULE15 RULE20
            reset_req.rt_restart    <= (lpd_state == WRM_LPD_ACT && scope == WRM_SCOPE_SUBSYS); // RULE15
        end
    end

endmodule : wrm_recovery_manager

// ---- sim/wrm_checker.sv ----
// Port timing checks for the recovery manager.
// Assumes ce stays high, so delays are plain cycles.
`timescale 1ns/1ps
module wrm_checker
    import wrm_pkg::*;
(
    input wire logic                    ref_clk,       // Clock
    input wire logic                    reset_n,       // Reset
    input wire wrm_pkg::wrm_err_irq_s   err_irq,       // Event
    input wire logic                    app_kick,      // Beat
    input wire logic                    fpd_report,    // Expiry
    input wire wrm_pkg::wrm_reset_req_s reset_req,     // Resets
    input wire logic                    idle_request,  // Idle
    input wire logic                    interval_mode, // Mode
    input wire logic                    bus_isolation  // Isolate
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    AST_IDLE_REC: assert property (idle_request |-> interval_mode) else $error("idle off");
    AST_ISO_REC: assert property (bus_isolation |-> interval_mode) else $error("iso off");
    AST_IDLE_SRC: assert property (idle_request |-> $past(err_irq, 3) == {1'b1, WRM_MASTER_APP, WRM_SRC_FPD_WDT})
        else $error("idle cause");
    AST_ISO_SRC: assert property (bus_isolation |-> $past(err_irq, 2) == {1'b1, WRM_MASTER_RT, WRM_SRC_LPD_WDT})
        else $error("iso cause");
    AST_ISO_SEQ: assert property (bus_isolation |=> !bus_isolation ##1 reset_req != 4'h0) else $error("iso seq");
    AST_FPD_KICK: assert property ($past(app_kick) |-> !fpd_report) else $error("kick ignored");
    AST_FPD_PULSE: assert property (fpd_report |=> !fpd_report) else $error("report long");
    AST_ONE_RST: assert property ($onehot0(reset_req)) else $error("two resets");
endmodule : wrm_checker
bind wrm_recovery_manager wrm_checker wrm_checker_inst (.ref_clk, .reset_n, .err_irq, .app_kick, .fpd_report,
    .reset_req, .idle_request, .interval_mode, .bus_isolation);

// ---- sim/wrm_partner.sv ----
// Error manager and cluster restart stand-in.
// Assumes one clock; restarts end DLY cycles after any request.
`timescale 1ns/1ps
module wrm_partner
    import wrm_pkg::*;
#(
    parameter int DLY = 5
) (
    input  wire logic                    ref_clk,    // Clock
    input  wire logic                    reset_n,    // Reset
    input  wire logic                    fpd_report, // Expiry
    input  wire logic                    lpd_report, // Expiry
    input  wire wrm_pkg::wrm_reset_req_s reset_req,  // Requests
    output wrm_pkg::wrm_err_irq_s        err_irq,    // Event
    output logic                         done        // Restart over
);
    logic [7:0] cnt; // Restart countdown
    // Each expiry is passed on, low-power winning if both come in one cycle; the manager must drop it without recovery
    always_ff @(posedge ref_clk) begin
        err_irq <= '0;
        if (reset_n && fpd_report) err_irq <= {1'b1, WRM_MASTER_APP, WRM_SRC_FPD_WDT};
        if (reset_n && lpd_report) err_irq <= {1'b1, WRM_MASTER_RT, WRM_SRC_LPD_WDT};
    end
    // Clusters finish a fixed time after any reset request
    always_ff @(posedge ref_clk) begin
        if (!reset_n) cnt <= 8'h00;
        else if (reset_req != 4'h0) cnt <= 8'(DLY);
        else if (cnt != 8'h00) cnt <= cnt - 8'h01;
    end
    assign done = (cnt == 8'h01);
endmodule : wrm_partner

// ---- sim/wrm_recovery_manager_bench.sv ----
// Bench: APB calls and heartbeat windows.
// Assumes a 10-cycle ms tick and 200-cycle domain watchdogs.
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module wrm_recovery_manager_bench;
    import wrm_pkg::*;
    logic ref_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, app_kick = 0, rt_kick = 0, err, pready, pslverr;
    logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
    logic [3:0] pstrb = 4'hf;
    logic fpd_report, lpd_report, idle_request, interval_mode, bus_isolation, done;
    wrm_err_irq_s err_irq;
    wrm_err_action_s err_action;
    wrm_reset_req_s reset_req, seen;
    int failures = 0, total_checks = 0, idle_n, iso_n, rpt_n;
    logic [11:0] fx [3] = '{12'h012, 12'h038, 12'h234};
    logic [3:0] lx [4] = '{4'h1, 4'h4, 4'h8, 4'h8};
    wrm_recovery_manager #(.MS_TICK(10), .FPD_TIMEOUT(200), .LPD_TIMEOUT(200), .CWD_TIMEOUT(600))
        wrm_recovery_manager_inst (.ref_clk, .reset_n, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .app_kick, .rt_kick, .err_irq, .app_restart_done(done),
        .rt_restart_done(done), .err_action, .fpd_report, .lpd_report, .reset_req, .idle_request, .interval_mode,
        .bus_isolation);
    wrm_partner wrm_partner_inst (.ref_clk, .reset_n, .fpd_report, .lpd_report, .reset_req, .err_irq, .done);
    initial forever #20 ref_clk = ~ref_clk;
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : final_report
    // One APB transfer, then an idle edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, 24'h0, a, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1 && ++n < 50);
        {rd, err} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
        if (n >= 50) begin failures++; final_report(); end
        @(posedge ref_clk);
    endtask : apb
    // Gather pulses
    task automatic run(input int n);
        {seen, idle_n, iso_n, rpt_n} = 100'h0;
        repeat (n) begin
            @(posedge ref_clk);
            seen = seen | reset_req;
            idle_n += idle_request;
            iso_n += bus_isolation;
            rpt_n += fpd_report;
        end
    endtask : run
    // Main sequence
    initial begin
        repeat (12) @(posedge ref_clk);
        reset_n <= 1'b1;
        apb(1'b1, REG_STATUS, 32'hff);
        apb(1'b0, REG_STATUS, 32'h0);
        `CHK("status", 32'h0, rd);
        apb(1'b0, 8'h08, 32'h0);
        `CHK("unmapped", 1'b1, err);
        app_kick <= 1'b1;
        run(1);
        app_kick <= 1'b0;
        run(230);
        `CHK("report", 1, rpt_n);
        `CHK("no idle", 0, idle_n);
        `CHK("fpd act", WRM_ACT_SYS_RESET, err_action.full_power_domain);
        `CHK("lpd act", WRM_ACT_SYS_RESET, err_action.low_power_domain);
        `CHK("ctl act", WRM_ACT_SYS_RESET, err_action.ctl);
        $display("test no recovery done");
        rt_kick <= 1'b1;
        // First expiry asks for idle, the next one escalates
        foreach (fx[i]) begin
            apb(1'b1, REG_CTRL, {24'h0, fx[i][11:4]});
            run(430);
            `CHK("interval", 1'b1, interval_mode);
            `CHK("fpd act", WRM_ACT_INTERRUPT, err_action.full_power_domain);
            `CHK("idle", 1, idle_n);
            `CHK("escalate", fx[i][3:0], seen);
        end
        app_kick <= 1'b1;
        $display("test full power done");
        foreach (lx[s]) begin
            apb(1'b1, REG_CTRL, {24'h0, 2'(s), 6'h01});
            rt_kick <= 1'b0;
            run(215);
            rt_kick <= 1'b1;
            `CHK("isolate", 1, iso_n);
            `CHK("scope", lx[s], seen);
        end
        $display("test low power done");
        apb(1'b1, REG_CTRL, 32'h1c);
        run(1100);
        apb(1'b0, REG_STATUS, 32'h0);
        `CHK("polling", 2'b01, rd[3:2]);
        apb(1'b1, REG_GEN_STORE5, 32'h1);
        run(1100);
        apb(1'b0, REG_STATUS, 32'h0);
        `CHK("armed", 2'b10, rd[3:2]);
        run(2000);
        `CHK("kicked", 4'h0, seen);
        apb(1'b1, REG_CTRL, 32'h14);
        apb(1'b0, REG_STATUS, 32'h0);
        `CHK("off", 2'b00, rd[3:2]);
        $display("test controller done");
        final_report();
    end
endmodule : wrm_recovery_manager_bench
